// File: hw/ddrini_ctrl.sv
// Controller end: makes the link clock and runs the power-up and mode register sequence.
//
// Operation
// - Hold CKE and ODT low during power-up.
// - Run stable clock 200 us first.
// - Drive NOP, then raise CKE.
// - NOP 400 ns after CKE, then precharge-all.
// - Write EMR2 with BA1 high.
// - Write EMR3 with BA0, BA1 high.
// - Write EMR1 enabling DLL, OCD bits low.
// - Mode register write with DLL reset.
// - Precharge-all, then two or more refreshes.
// - Mode register write without DLL reset.
// - Calibration only 200 clocks after DLL reset.
// - EMR1 calibration default, then calibration exit.
// - Every register write carries all fields.
// - Device keeps array data across mode writes.
// - Mode write is all-low command, bank selects.
// - Write modes idle, CKE high, respect tMRD.
// - Program every mode register before use.
// - Mode register field layout.
// - Extended mode register 1 field layout.
// - Write recovery rounded up in cycles.
// - DLL off in self refresh, relocked after.
// - No read before 200 clocks after DLL reset.
`timescale 1ns/1ps
module ddrini_ctrl
	import ddrini_pkg::*;
#(
	parameter int CLK_STABLE_CYC = T_CLK_STABLE_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire logic [13:0] mr_cfg,
	input  wire logic [13:0] emr1_cfg,
	output logic             busy,
	output logic             init_done,
	output logic             read_ok,
	ddrini_link_if.ctrl      link
);
	typedef enum logic [13:0] {
		ST_IDLE    = 14'h0001,
		ST_CLKWAIT = 14'h0002,
		ST_CKEUP   = 14'h0004,
		ST_EMR2    = 14'h0010,
		ST_EMR3    = 14'h0020,
		ST_EMR1    = 14'h0040,
		ST_MRDLL   = 14'h0080,
		ST_PREA2   = 14'h0100,
		ST_REF     = 14'h0200,
		ST_MROP    = 14'h0400,
		ST_OCDDEF  = 14'h0800,
		ST_OCDEXIT = 14'h1000,
		ST_DONE    = 14'h2000
	} ddrini_state_t;

	// Builds a full extended mode register 1 word with the calibration field forced.
	function automatic logic [13:0] ddrini_emr1(input logic [13:0] cfg, input logic [2:0] ocd);
		logic [13:0] w;
		w = cfg;
		w[EMR_OCD_LO +: 3] = ocd;
		w[EMR_DLLDIS] = 1'b0;
		w[A_TOP] = 1'b0;
		return w;
	endfunction

	ddrini_state_t state;
	ddrini_state_t next_state;
	logic [15:0]   wait_cnt;
	logic [15:0]   next_wait_cnt;
	logic [15:0]   dll_cnt;
	logic [15:0]   next_dll_cnt;
	logic [1:0]    ref_cnt;
	logic [1:0]    next_ref_cnt;
	logic          ck;
	logic          cke;
	logic [3:0]    cmd;
	logic [3:0]    next_cmd;
	logic [2:0]    ba;
	logic [2:0]    next_ba;
	logic [13:0]   addr;
	logic [13:0]   next_addr;
	logic          next_cke;
	logic          next_busy;
	logic          next_init_done;
	logic          next_read_ok;
	logic          tick;
	logic          go;

	// Commands change only as the link clock falls, so each is held for a full
	// link period and is stable around the rising edge the device samples on.
	assign tick = ck;
	assign go   = tick && (wait_cnt == 16'h0000);

	// Sequence step, wait counters and the command word for the next link period.
	always_comb begin
		next_state     = state;
		next_wait_cnt  = (wait_cnt != 16'h0000) ? wait_cnt - 16'h0001 : wait_cnt;
		next_dll_cnt   = (dll_cnt != 16'h0000) ? dll_cnt - 16'h0001 : dll_cnt;
		next_ref_cnt   = ref_cnt;
		next_cke       = cke;
		next_cmd       = tick ? CMD_NOP : cmd;
		next_ba        = tick ? BA_MR : ba;
		next_addr      = tick ? ADDR_ZERO : addr;
		next_busy      = (state != ST_IDLE) && (state != ST_DONE);
		next_init_done = (state == ST_DONE);
		next_read_ok   = (state == ST_DONE) && (dll_cnt == 16'h0000);
		unique case (state)
			ST_IDLE: begin
				next_cke = 1'b0;
				if (start) begin
					next_state    = ST_CLKWAIT;
					next_wait_cnt = 16'(CLK_STABLE_CYC);
				end
			end
			ST_CLKWAIT: begin
				if (go) begin
					next_state    = ST_CKEUP;
					next_cke      = 1'b1;
					next_wait_cnt = 16'(T_CKE_CYC);
				end
			end
			ST_CKEUP: begin
				if (go) begin
					next_cmd             = CMD_PRE;
					next_addr[A_PREALL]  = 1'b1;
					next_state           = ST_EMR2;
					next_wait_cnt        = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_EMR2: begin
				if (go) begin
					next_cmd      = CMD_MRS;
					next_ba       = BA_EMR2;
					next_state    = ST_EMR3;
					next_wait_cnt = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_EMR3: begin
				if (go) begin
					next_cmd      = CMD_MRS;
					next_ba       = BA_EMR3;
					next_state    = ST_EMR1;
					next_wait_cnt = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_EMR1: begin
				if (go) begin
					next_cmd      = CMD_MRS;
					next_ba       = BA_EMR1;
					next_addr     = ddrini_emr1(emr1_cfg, OCD_EXIT);
					next_state    = ST_MRDLL;
					next_wait_cnt = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_MRDLL: begin
				if (go) begin
					next_cmd              = CMD_MRS;
					next_addr             = mr_cfg;
					next_addr[MR_DLLRST]  = 1'b1;
					next_addr[MR_TM]      = 1'b0;
					next_addr[A_TOP]      = 1'b0;
					next_dll_cnt          = 16'(DLL_LOCK_CYC);
					next_state            = ST_PREA2;
					next_wait_cnt         = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_PREA2: begin
				if (go) begin
					next_cmd            = CMD_PRE;
					next_addr[A_PREALL] = 1'b1;
					next_ref_cnt        = 2'(MIN_REFRESHES);
					next_state          = ST_REF;
					next_wait_cnt       = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_REF: begin
				if (go) begin
					next_cmd      = CMD_REF;
					next_ref_cnt  = ref_cnt - 2'h1;
					next_wait_cnt = 16'(T_CMD_GAP_CYC);
					if (ref_cnt == 2'h1) begin
						next_state = ST_MROP;
					end
				end
			end
			ST_MROP: begin
				if (go) begin
					next_cmd             = CMD_MRS;
					next_addr            = mr_cfg;
					next_addr[MR_DLLRST] = 1'b0;
					next_addr[MR_TM]     = 1'b0;
					next_addr[A_TOP]     = 1'b0;
					next_state           = ST_OCDDEF;
					next_wait_cnt        = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_OCDDEF: begin
				if (go && (dll_cnt == 16'h0000)) begin
					next_cmd      = CMD_MRS;
					next_ba       = BA_EMR1;
					next_addr     = ddrini_emr1(emr1_cfg, OCD_DEFAULT);
					next_state    = ST_OCDEXIT;
					next_wait_cnt = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_OCDEXIT: begin
				if (go) begin
					next_cmd      = CMD_MRS;
					next_ba       = BA_EMR1;
					next_addr     = ddrini_emr1(emr1_cfg, OCD_EXIT);
					next_state    = ST_DONE;
					next_wait_cnt = 16'(T_CMD_GAP_CYC);
				end
			end
			ST_DONE: begin
				if (start) begin
					// A new start reruns the sequence from the precharge-all, skipping the clock wait; the array is never touched.
					next_state = ST_CKEUP;
					next_wait_cnt = 16'(T_CMD_GAP_CYC);
				end
			end
		endcase
	end

	// All state and link outputs except the tied-low ODT are plain flip-flops; the link clock is a divide by two.
	// Reset parks the link clock high, so the device end takes its own reset on that rising
	// edge; reset must therefore stay low for at least two core clocks.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state     <= ST_IDLE;
			wait_cnt  <= 16'h0000;
			dll_cnt   <= 16'h0000;
			ref_cnt   <= 2'h0;
			ck        <= 1'b1;
			cke       <= 1'b0;
			cmd       <= CMD_NOP;
			ba        <= BA_MR;
			addr      <= ADDR_ZERO;
			busy      <= 1'b0;
			init_done <= 1'b0;
			read_ok   <= 1'b0;
		end else begin
			state     <= next_state;
			wait_cnt  <= next_wait_cnt;
			dll_cnt   <= next_dll_cnt;
			ref_cnt   <= next_ref_cnt;
			ck        <= ~ck;
			cke       <= next_cke;
			cmd       <= next_cmd;
			ba        <= next_ba;
			addr      <= next_addr;
			busy      <= next_busy;
			init_done <= next_init_done;
			read_ok   <= next_read_ok;
		end
	end

	// Link pins; ODT stays low for the whole sequence.
	assign link.ck    = ck;
	assign link.cke   = cke;
	assign link.odt   = 1'b0;
	assign link.cs_b  = cmd[3];
	assign link.ras_b = cmd[2];
	assign link.cas_b = cmd[1];
	assign link.we_b  = cmd[0];
	assign link.ba    = ba;
	assign link.addr  = addr;
endmodule

// File: hw/ddrini_dram.sv
// Device end: decodes mode register writes and tracks the DLL, clocked by the link clock.
`timescale 1ns/1ps
module ddrini_dram
	import ddrini_pkg::*;
(
	input  wire logic        rst_b,
	ddrini_link_if.dram      link,
	output logic [13:0]      mr,
	output logic [13:0]      emr1,
	output logic [13:0]      emr2,
	output logic [13:0]      emr3,
	output logic             burst_8,
	output logic [2:0]       cas_lat,
	output logic [2:0]       wr_cyc,
	output logic [2:0]       add_lat,
	output logic [2:0]       ocd_mode,
	output logic             dll_ready,
	output logic             self_ref,
	output logic             bad_mode
);
	typedef enum logic [2:0] {
		DLL_OFF  = 3'h1,
		DLL_LOCK = 3'h2,
		DLL_RUN  = 3'h4
	} ddrini_dll_t;

	ddrini_dll_t dll;
	ddrini_dll_t next_dll;
	logic [7:0]  lock_cnt;
	logic [7:0]  next_lock_cnt;
	logic [3:0]  cmd;
	logic        mode_wr;
	logic        sr_enter;
	logic        sr_exit;
	logic        next_self_ref;
	logic        next_bad_mode;

	// Command decode; a mode write needs CKE high and the all-low command.
	assign cmd      = {link.cs_b, link.ras_b, link.cas_b, link.we_b};
	assign mode_wr  = link.cke && !self_ref && (cmd == CMD_MRS);
	assign sr_enter = link.cke == 1'b0 && !self_ref && (cmd == CMD_REF);
	assign sr_exit  = self_ref && link.cke;

	// DLL state: a write with the reset bit or leaving self refresh starts a fresh lock.
	always_comb begin
		next_dll      = dll;
		next_lock_cnt = (lock_cnt != 8'h00) ? lock_cnt - 8'h01 : lock_cnt;
		next_self_ref = self_ref;
		next_bad_mode = bad_mode;
		if (sr_enter) begin
			next_self_ref = 1'b1;
			next_dll      = DLL_OFF;
		end else if (sr_exit) begin
			next_self_ref = 1'b0;
			next_dll      = emr1[EMR_DLLDIS] ? DLL_OFF : DLL_LOCK;
			next_lock_cnt = 8'(DLL_LOCK_CLKS);
		end else if (mode_wr && link.ba == BA_EMR1 && link.addr[EMR_DLLDIS]) begin
			next_dll = DLL_OFF;
		end else if (mode_wr && link.ba == BA_MR && link.addr[MR_DLLRST]) begin
			next_dll      = emr1[EMR_DLLDIS] ? DLL_OFF : DLL_LOCK;
			next_lock_cnt = 8'(DLL_LOCK_CLKS);
		end else if (dll == DLL_LOCK && lock_cnt == 8'h01) begin
			next_dll = DLL_RUN;
		end
		// Only 4 and 8 bursts, CAS latencies of 2 and up and test mode off are accepted.
		if (mode_wr && link.ba == BA_MR) begin
			next_bad_mode = !(link.addr[MR_BL_LO +: 3] == BL_4 || link.addr[MR_BL_LO +: 3] == BL_8)
				|| link.addr[MR_TM] || link.addr[MR_CL_LO +: 3] < 3'h2;
		end
	end

	// Registers hold whatever was last written; nothing here touches the array.
	always_ff @(posedge link.ck) begin
		if (!rst_b) begin
			mr        <= ADDR_ZERO;
			emr1      <= ADDR_ZERO;
			emr2      <= ADDR_ZERO;
			emr3      <= ADDR_ZERO;
			dll       <= DLL_OFF;
			lock_cnt  <= 8'h00;
			self_ref  <= 1'b0;
			bad_mode  <= 1'b0;
			dll_ready <= 1'b0;
		end else begin
			if (mode_wr) begin
				unique case (link.ba)
					BA_MR:   mr   <= link.addr;
					BA_EMR1: emr1 <= link.addr;
					BA_EMR2: emr2 <= link.addr;
					BA_EMR3: emr3 <= link.addr;
					default: mr   <= mr;
				endcase
			end
			dll       <= next_dll;
			lock_cnt  <= next_lock_cnt;
			self_ref  <= next_self_ref;
			bad_mode  <= next_bad_mode;
			dll_ready <= (next_dll == DLL_RUN);
		end
	end

	// Decoded fields track the stored words one link clock later.
	always_ff @(posedge link.ck) begin
		if (!rst_b) begin
			burst_8  <= 1'b0;
			cas_lat  <= 3'h0;
			wr_cyc   <= 3'h0;
			add_lat  <= 3'h0;
			ocd_mode <= 3'h0;
		end else begin
			burst_8  <= mr[MR_BL_LO +: 3] == BL_8;
			cas_lat  <= mr[MR_CL_LO +: 3];
			wr_cyc   <= mr[MR_WR_LO +: 3] + 3'h1;
			add_lat  <= emr1[EMR_AL_LO +: 3];
			ocd_mode <= emr1[EMR_OCD_LO +: 3];
		end
	end
endmodule

// File: hw/ddrini_link_if.sv
// Command and address link between the memory controller and the DDR2 device.
`timescale 1ns/1ps
interface ddrini_link_if;
	logic        ck;
	logic        cke;
	logic        odt;
	logic        cs_b;
	logic        ras_b;
	logic        cas_b;
	logic        we_b;
	logic [2:0]  ba;
	logic [13:0] addr;
	modport ctrl (output ck, cke, odt, cs_b, ras_b, cas_b, we_b, ba, addr);
	modport dram (input ck, cke, odt, cs_b, ras_b, cas_b, we_b, ba, addr);
endinterface

// File: hw/ddrini_pkg.sv
// Shared constants for the DDR2 power-up initialization link.
package ddrini_pkg;
	// Command codes as {cs_b, ras_b, cas_b, we_b}.
	localparam logic [3:0] CMD_MRS   = 4'h0;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_DESEL = 4'h8;
	// Bank address codes that select the mode registers.
	localparam logic [2:0] BA_MR   = 3'h0;
	localparam logic [2:0] BA_EMR1 = 3'h1;
	localparam logic [2:0] BA_EMR2 = 3'h2;
	localparam logic [2:0] BA_EMR3 = 3'h3;
	// Field positions on the address lines.
	localparam int A_PREALL   = 10;
	localparam int A_TOP      = 13;
	localparam int MR_BL_LO   = 0;
	localparam int MR_BT      = 3;
	localparam int MR_CL_LO   = 4;
	localparam int MR_TM      = 7;
	localparam int MR_DLLRST  = 8;
	localparam int MR_WR_LO   = 9;
	localparam int EMR_DLLDIS = 0;
	localparam int EMR_RDS    = 1;
	localparam int EMR_RTT0   = 2;
	localparam int EMR_AL_LO  = 3;
	localparam int EMR_RTT1   = 6;
	localparam int EMR_OCD_LO = 7;
	localparam int EMR_DQSDIS = 10;
	// Field codes.
	localparam logic [2:0] BL_4        = 3'h2;
	localparam logic [2:0] BL_8        = 3'h3;
	localparam logic [2:0] OCD_EXIT    = 3'h0;
	localparam logic [2:0] OCD_DEFAULT = 3'h7;
	localparam logic [13:0] ADDR_ZERO  = 14'h0000;
	// Timing: core clock period and the documented waits.
	localparam int CORE_PERIOD_PS  = 25000;
	localparam int LINK_DIV        = 2;
	localparam int T_CLK_STABLE_US = 200;
	localparam int T_CLK_STABLE_CYC = (T_CLK_STABLE_US * 1000000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	localparam int T_CKE_NS        = 400;
	localparam int T_CKE_CYC       = (T_CKE_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	localparam int T_CMD_GAP_NS    = 200;
	localparam int T_CMD_GAP_CYC   = (T_CMD_GAP_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	localparam int DLL_LOCK_CLKS   = 200;
	localparam int DLL_LOCK_CYC    = DLL_LOCK_CLKS * LINK_DIV;
	localparam int MIN_REFRESHES   = 2;
endpackage

// File: verification/ddrini_link_props.sv
// Checker for the command sequence that the controller drives onto the link.
`timescale 1ns/1ps
module ddrini_link_props
	import ddrini_pkg::*;
(
	input wire logic        rst_b,
	input wire logic        ck,
	input wire logic        cke,
	input wire logic        odt,
	input wire logic        cs_b,
	input wire logic        ras_b,
	input wire logic        cas_b,
	input wire logic        we_b,
	input wire logic [2:0]  ba,
	input wire logic [13:0] addr
);
	localparam logic [3:0] SEQ_CMD [11] = '{CMD_PRE, CMD_MRS, CMD_MRS, CMD_MRS, CMD_MRS, CMD_PRE,
		CMD_REF, CMD_REF, CMD_MRS, CMD_MRS, CMD_MRS};
	localparam logic [2:0] SEQ_BA [11] = '{BA_MR, BA_EMR2, BA_EMR3, BA_EMR1, BA_MR, BA_MR,
		BA_MR, BA_MR, BA_MR, BA_EMR1, BA_EMR1};
	logic [3:0] cmd;
	logic       act;
	logic [3:0] step;
	logic [9:0] since_rst;
	default clocking cb @(posedge ck); endclocking
	default disable iff (!rst_b);
	// Any selected command other than a no-op counts as one step.
	assign cmd = {cs_b, ras_b, cas_b, we_b};
	assign act = !cs_b && (cmd != CMD_NOP);
	// Step and DLL-age tracking; cleared asynchronously because the link clock may rest in reset.
	always_ff @(posedge ck or negedge rst_b) begin
		if (!rst_b) begin
			step <= 4'h0;
			since_rst <= 10'h3FF;
		end else begin
			if (act)
				step <= (step == 4'hA) ? 4'h0 : step + 4'h1;
			if (act && step == 4'h4)
				since_rst <= 10'h001;
			else if (since_rst != 10'h3FF)
				since_rst <= since_rst + 10'h001;
		end
	end
	odt_held_low_a: assert property (odt == 1'b0) else $error("odt driven high");
	cke_wait_nop_a: assert property ($rose(cke) |-> (cmd == CMD_NOP)[*8]) else $error("command within cke wait");
	seq_order_a: assert property (act |-> cmd == SEQ_CMD[step]) else $error("command out of order");
	seq_bank_a: assert property (act && cmd == CMD_MRS |-> ba == SEQ_BA[step]) else $error("wrong bank");
	dll_enable_a: assert property (act && step == 4'h3 |-> addr[0] == 1'b0 && addr[9:7] == 3'h0 && !addr[13])
		else $error("dll enable word wrong");
	dll_reset_a: assert property (act && step == 4'h4 |-> addr[8] && !addr[13]) else $error("dll reset word wrong");
	final_mr_a: assert property (act && step == 4'h8 |-> !addr[8] && !addr[7]) else $error("final mode word wrong");
	ocd_default_a: assert property (act && step == 4'h9 |-> addr[9:7] == OCD_DEFAULT && since_rst >= 10'h0C8)
		else $error("calibration default wrong");
	ocd_exit_a: assert property (act && step == 4'hA |-> addr[9:7] == OCD_EXIT) else $error("calibration exit wrong");
	prech_all_a: assert property (act && cmd == CMD_PRE |-> addr[A_PREALL]) else $error("precharge not all");
	mrs_gap_a: assert property (act && cmd == CMD_MRS |-> cke ##1 cmd == CMD_NOP) else $error("mode write gap");
endmodule

// File: verification/ddrini_tb.sv
// Bench: both link ends back to back, plus a bench-driven device end for refused commands and the DLL and self refresh checks.
`timescale 1ns/1ps
module ddrini_tb;
	import ddrini_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b    = 1'b0;
	logic        start    = 1'b0;
	logic [13:0] mr_cfg   = 14'h0000;
	logic [13:0] emr1_cfg = 14'h0000;
	logic        busy, init_done, read_ok, burst_8, dll_ready, self_ref, bad_mode, f_self, f_dll;
	logic [13:0] mr, emr1, emr2, emr3, mr_f;
	logic [2:0]  cas_lat, wr_cyc, add_lat, ocd_mode;
	int          errors = 0;
	int          checks = 0;
	ddrini_link_if link ();
	ddrini_link_if flink ();
	ddrini_ctrl #(.CLK_STABLE_CYC(20)) ddrini_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .start(start),
		.mr_cfg(mr_cfg), .emr1_cfg(emr1_cfg), .busy(busy), .init_done(init_done), .read_ok(read_ok), .link(link));
	ddrini_dram ddrini_dram_i (.rst_b(rst_b), .link(link), .mr(mr), .emr1(emr1), .emr2(emr2), .emr3(emr3),
		.burst_8(burst_8), .cas_lat(cas_lat), .wr_cyc(wr_cyc), .add_lat(add_lat), .ocd_mode(ocd_mode),
		.dll_ready(dll_ready), .self_ref(self_ref), .bad_mode(bad_mode));
	ddrini_dram ddrini_dram_fault_i (.rst_b(rst_b), .link(flink), .mr(mr_f), .emr1(), .emr2(), .emr3(),
		.burst_8(), .cas_lat(), .wr_cyc(), .add_lat(), .ocd_mode(), .dll_ready(f_dll), .self_ref(f_self),
		.bad_mode());
	ddrini_link_props ddrini_link_props_i (.rst_b(rst_b), .ck(link.ck), .cke(link.cke), .odt(link.odt),
		.cs_b(link.cs_b), .ras_b(link.ras_b), .cas_b(link.cas_b), .we_b(link.we_b), .ba(link.ba), .addr(link.addr));
	// Core clock at 40 MHz and a free-running 6 ns clock for the bench-driven device end.
	always #12.5 core_clk = ~core_clk;
	always #3 flink.ck = ~flink.ck;
	// Bench-driven link starts powered down with a no-op on the command pins.
	initial begin
		flink.ck = 1'b0;
		flink.cke = 1'b0;
		flink.odt = 1'b0;
		{flink.cs_b, flink.ras_b, flink.cas_b, flink.we_b} = CMD_NOP;
		flink.ba = 3'h0;
		flink.addr = ADDR_ZERO;
	end
	task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One command for one link period on the bench-driven end, then no-ops so it settles.
	task automatic fcmd(input logic c, input logic [3:0] k, input logic [2:0] b, input logic [13:0] a);
		@(negedge flink.ck);
		flink.cke = c;
		{flink.cs_b, flink.ras_b, flink.cas_b, flink.we_b} = k;
		flink.ba = b;
		flink.addr = a;
		@(negedge flink.ck);
		{flink.cs_b, flink.ras_b, flink.cas_b, flink.we_b} = CMD_NOP;
		repeat (3) @(negedge flink.ck);
	endtask
	// Full sequence with given operating words; forced bits are cleared in the expectations.
	task automatic run_init(input logic [13:0] m, input logic [13:0] e, input logic b);
		int n;
		@(negedge core_clk);
		mr_cfg = m;
		emr1_cfg = e;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		@(negedge core_clk);
		chk("busy", 14'(busy), 14'h0001);
		n = 0;
		while (init_done !== 1'b1 && n < 4000) begin
			@(negedge core_clk);
			n++;
		end
		chk("init_done", 14'(init_done), 14'h0001);
		repeat (4) @(negedge core_clk);
		chk("mr", mr, m & ~14'h2180);
		chk("emr1", emr1, e & ~14'h2381);
		chk("emr2", emr2, ADDR_ZERO);
		chk("emr3", emr3, ADDR_ZERO);
		chk("burst_8", 14'(burst_8), 14'(m[2:0] == BL_8));
		chk("cas_lat", 14'(cas_lat), 14'(m[6:4]));
		chk("wr_cyc", 14'(wr_cyc), 14'(m[11:9] + 3'h1));
		chk("bad_mode", 14'(bad_mode), 14'(b));
		chk("add_lat", 14'(add_lat), 14'(e[5:3]));
		chk("ocd_mode", 14'(ocd_mode), 14'(OCD_EXIT));
		chk("dll_ready", 14'(dll_ready), 14'h0001);
		chk("read_ok", 14'(read_ok), 14'h0001);
		chk("busy_done", 14'(busy), 14'h0000);
	endtask
	// A rerun from the ready state rewrites every register; MR and EMR1 get new words, EMR2 and EMR3 get zero again.
	initial begin
		repeat (4) @(negedge core_clk);
		rst_b = 1'b1;
		run_init(14'h05B3, 14'h0693, 1'b0);
		run_init(14'h0A12, 14'h0008, 1'b1);
		fcmd(1'b0, CMD_MRS, BA_MR, 14'h0433);
		chk("mr_cke_low", mr_f, ADDR_ZERO);
		fcmd(1'b1, CMD_MRS, BA_MR, 14'h0433);
		chk("mr_write", mr_f, 14'h0433);
		fcmd(1'b1, CMD_MRS, 3'h4, 14'h0001);
		chk("mr_bank4", mr_f, 14'h0433);
		// A DLL reset must lock first, so that self refresh entry really turns it off.
		fcmd(1'b1, CMD_MRS, BA_MR, 14'h0533);
		chk("dll_locking", 14'(f_dll), 14'h0000);
		repeat (200) @(negedge flink.ck);
		chk("dll_locked", 14'(f_dll), 14'h0001);
		fcmd(1'b0, CMD_REF, BA_MR, ADDR_ZERO);
		chk("self_ref", 14'(f_self), 14'h0001);
		chk("dll_off", 14'(f_dll), 14'h0000);
		fcmd(1'b1, CMD_NOP, BA_MR, ADDR_ZERO);
		chk("self_ref_exit", 14'(f_self), 14'h0000);
		chk("dll_relock", 14'(f_dll), 14'h0000);
		repeat (200) @(negedge flink.ck);
		chk("dll_relocked", 14'(f_dll), 14'h0001);
		wrap_up();
	end
	// Both runs finish in about five hundred cycles each; a hang is cut well beyond that.
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		wrap_up();
	end
endmodule
